// ### rtl/ddrbl_pkg.sv
// package: constants and carrier types for the ddr bus byte-lane block
package ddrbl_pkg;

  // widths of the bus and of one transferred word
  localparam int unsigned DDRBL_BYTE_W = 8;
  localparam int unsigned DDRBL_WORD_W = 16;

  // byte positions inside a word: first byte on the bus is byte a
  localparam int unsigned DDRBL_BYTE_A_MSB = 15;
  localparam int unsigned DDRBL_BYTE_A_LSB = 8;
  localparam int unsigned DDRBL_BYTE_B_MSB = 7;
  localparam int unsigned DDRBL_BYTE_B_LSB = 0;
  localparam int unsigned DDRBL_EN_A = 1;
  localparam int unsigned DDRBL_EN_B = 0;

  // synchroniser depth for every pin input
  localparam int unsigned DDRBL_SYNC_STAGES = 2;

  // values after reset, and the enable for a whole word
  localparam logic [7:0] DDRBL_DQ_RST = 8'h00;
  localparam logic [15:0] DDRBL_WORD_RST = 16'h0000;
  localparam logic [1:0] DDRBL_EN_RST = 2'h0;
  localparam logic [1:0] DDRBL_EN_ALL = 2'h3;

  // one sampled view of the bus pins
  typedef struct packed {
    logic bus_clk;
    logic cs_b;
    logic rs_wm;
    logic [7:0] dq;
  } ddrbl_pins_s;

  // one word handed to the array, with its byte enables
  typedef struct packed {
    logic [15:0] data;
    logic [1:0] byte_en;
  } ddrbl_wr_word_s;

  // phase of a read data strobe cycle
  typedef enum logic [2:0] {
    DDRBL_RD_IDLE = 3'b001,
    DDRBL_RD_HIGH = 3'b010,
    DDRBL_RD_LOW  = 3'b100
  } ddrbl_rd_state_e;

endpackage

// ### rtl/ddrbl_lane.sv
// device-side byte-lane placement and strobe/mask logic for the ddr memory bus
`timescale 1ns/100ps
`default_nettype none

module ddrbl_lane
  import ddrbl_pkg::*;
#(
  parameter bit ZL_DRIVE_LOW = 1'b1 // strobe driven low, else floated, in zero-latency writes
) (
  // clock, reset and enable
  input wire logic REF_CLK_IN,
  input wire logic RST_B_IN,
  input wire logic CE_IN,
  // bus pins from the host
  input wire logic BUS_CLOCK_IN,
  input wire logic CS_B_IN,
  input wire logic [7:0] DQ_IN,
  input wire logic READ_STROBE_WRITE_MASK_IN,
  // bus pins driven by the device
  output logic [7:0] DQ_OUT,
  output logic DQ_OE_OUT,
  output logic READ_STROBE_WRITE_MASK_OUT,
  output logic READ_STROBE_WRITE_MASK_OE_OUT,
  // phase control from the transaction sequencer
  input wire logic RD_PHASE_IN,
  input wire logic WR_PHASE_IN,
  input wire logic WR_ZERO_LAT_IN,
  // read word source from the array
  input wire logic [15:0] RD_WORD_IN,
  output logic RD_WORD_TAKEN_OUT,
  // write word sink towards the array
  output logic [15:0] WR_WORD_OUT,
  output logic [1:0] WR_BYTE_EN_OUT,
  output logic WR_VALID_OUT
);

  logic rst_meta_q;
  logic rst_sync_q;
  ddrbl_pins_s pins_raw;
  ddrbl_pins_s pins_meta_q;
  ddrbl_pins_s pins_q;
  logic clk_prev_q;
  logic clk_rise;
  logic clk_fall;
  logic active;
  logic [7:0] byte_a_q;
  logic en_a_q;
  logic have_a_q;
  ddrbl_wr_word_s wr_q;
  logic wr_valid_q;
  ddrbl_rd_state_e rd_state_q;
  logic [15:0] rd_word_q;
  logic rd_taken_q;
  logic [7:0] dq_q;
  logic dq_oe_q;
  logic rs_q;
  logic rs_oe_q;

  // reset release through two flip-flops
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else if (CE_IN) begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign pins_raw = '{bus_clk: BUS_CLOCK_IN, cs_b: CS_B_IN,
                      rs_wm: READ_STROBE_WRITE_MASK_IN, dq: DQ_IN};

  // two-stage synchroniser for all pins; clock and data share the same delay
  always_ff @(posedge REF_CLK_IN or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      pins_meta_q <= '{bus_clk: 1'b0, cs_b: 1'b1, rs_wm: 1'b0, dq: DDRBL_DQ_RST};
      pins_q <= '{bus_clk: 1'b0, cs_b: 1'b1, rs_wm: 1'b0, dq: DDRBL_DQ_RST};
    end else if (CE_IN) begin
      pins_meta_q <= pins_raw;
      pins_q <= pins_meta_q;
    end
  end

  // bus clock edge detection on the synchronised copy
  always_ff @(posedge REF_CLK_IN or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      clk_prev_q <= 1'b0;
    end else if (CE_IN) begin
      clk_prev_q <= pins_q.bus_clk;
    end
  end

  assign clk_rise = CE_IN && pins_q.bus_clk && !clk_prev_q;
  assign clk_fall = CE_IN && !pins_q.bus_clk && clk_prev_q;
  assign active = !pins_q.cs_b;

  // write byte a: taken on the rising bus clock, mask sampled with it
  // host keeps data centred on the edge, so the synchronised sample is clean
  always_ff @(posedge REF_CLK_IN or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      byte_a_q <= DDRBL_DQ_RST;
      en_a_q <= 1'b0;
      have_a_q <= 1'b0;
    end else if (CE_IN) begin
      if (!active || !WR_PHASE_IN) begin
        have_a_q <= 1'b0; // a frame that ends mid-word drops the lone byte
      end else if (clk_rise) begin
        byte_a_q <= pins_q.dq; // first byte on the bus is byte a
        en_a_q <= WR_ZERO_LAT_IN || !pins_q.rs_wm; // mask low keeps the byte
        have_a_q <= 1'b1;
      end else if (clk_fall) begin
        have_a_q <= 1'b0;
      end
    end
  end

  // write byte b: taken on the falling bus clock, completing the word
  always_ff @(posedge REF_CLK_IN or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      wr_q <= '{data: DDRBL_WORD_RST, byte_en: DDRBL_EN_RST};
      wr_valid_q <= 1'b0;
    end else if (CE_IN) begin
      wr_valid_q <= 1'b0;
      if (active && WR_PHASE_IN && clk_fall && have_a_q) begin
        // byte a lands in the upper half, byte b in the lower
        wr_q.data[DDRBL_BYTE_A_MSB:DDRBL_BYTE_A_LSB] <= byte_a_q;
        wr_q.data[DDRBL_BYTE_B_MSB:DDRBL_BYTE_B_LSB] <= pins_q.dq;
        if (WR_ZERO_LAT_IN) begin
          wr_q.byte_en <= DDRBL_EN_ALL; // whole word, no masking
        end else begin
          wr_q.byte_en[DDRBL_EN_A] <= en_a_q;
          wr_q.byte_en[DDRBL_EN_B] <= !pins_q.rs_wm;
        end
        wr_valid_q <= 1'b1;
      end
    end
  end

  // read strobe sequencer: high half carries byte a, low half carries byte b
  always_ff @(posedge REF_CLK_IN or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rd_state_q <= DDRBL_RD_IDLE;
      rd_word_q <= DDRBL_WORD_RST;
      rd_taken_q <= 1'b0;
    end else if (CE_IN) begin
      rd_taken_q <= 1'b0;
      if (!active || !RD_PHASE_IN) begin
        rd_state_q <= DDRBL_RD_IDLE;
      end else begin
        unique case (rd_state_q)
          DDRBL_RD_IDLE, DDRBL_RD_LOW: begin
            if (clk_rise) begin
              rd_word_q <= RD_WORD_IN; // one word per bus clock
              rd_taken_q <= 1'b1;
              rd_state_q <= DDRBL_RD_HIGH;
            end
          end
          DDRBL_RD_HIGH: begin
            if (clk_fall) begin
              rd_state_q <= DDRBL_RD_LOW;
            end
          end
        endcase
      end
    end
  end

  // pin drivers: data changes together with the strobe, edge aligned
  always_ff @(posedge REF_CLK_IN or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      dq_q <= DDRBL_DQ_RST;
      dq_oe_q <= 1'b0;
      rs_q <= 1'b0;
      rs_oe_q <= 1'b0;
    end else if (CE_IN) begin
      if (active && RD_PHASE_IN && clk_rise) begin
        // same stored positions come back out, so either byte order survives
        dq_q <= RD_WORD_IN[DDRBL_BYTE_A_MSB:DDRBL_BYTE_A_LSB];
        rs_q <= 1'b1;
        dq_oe_q <= 1'b1;
        rs_oe_q <= 1'b1;
      end else if (active && RD_PHASE_IN && clk_fall && rd_state_q == DDRBL_RD_HIGH) begin
        dq_q <= rd_word_q[DDRBL_BYTE_B_MSB:DDRBL_BYTE_B_LSB];
        rs_q <= 1'b0;
      end else if (active && RD_PHASE_IN) begin
        rs_oe_q <= 1'b1; // strobe held, low until the first word
        dq_oe_q <= rd_state_q != DDRBL_RD_IDLE;
      end else if (active && WR_PHASE_IN && WR_ZERO_LAT_IN) begin
        rs_q <= 1'b0; // host leaves the line free here
        rs_oe_q <= ZL_DRIVE_LOW;
        dq_oe_q <= 1'b0;
      end else begin
        rs_q <= 1'b0;
        rs_oe_q <= 1'b0;
        dq_oe_q <= 1'b0;
      end
    end
  end

  assign DQ_OUT = dq_q;
  assign DQ_OE_OUT = dq_oe_q;
  assign READ_STROBE_WRITE_MASK_OUT = rs_q;
  assign READ_STROBE_WRITE_MASK_OE_OUT = rs_oe_q;
  assign RD_WORD_TAKEN_OUT = rd_taken_q;
  assign WR_WORD_OUT = wr_q.data;
  assign WR_BYTE_EN_OUT = wr_q.byte_en;
  assign WR_VALID_OUT = wr_valid_q;

endmodule

`default_nettype wire

// ### testbench/ddrbl_lane_assertions.sv
// checker: timing relations between the lane block's ports
`timescale 1ns/100ps
`default_nettype none
module ddrbl_lane_assertions
  import ddrbl_pkg::*;
(
  input wire logic REF_CLK_IN,
  input wire logic RST_B_IN,
  input wire logic RD_PHASE_IN,
  input wire logic WR_PHASE_IN,
  input wire logic WR_ZERO_LAT_IN,
  input wire logic [15:0] RD_WORD_IN,
  input wire logic [7:0] DQ_OUT,
  input wire logic DQ_OE_OUT,
  input wire logic READ_STROBE_WRITE_MASK_OUT,
  input wire logic READ_STROBE_WRITE_MASK_OE_OUT,
  input wire logic RD_WORD_TAKEN_OUT,
  input wire logic [1:0] WR_BYTE_EN_OUT,
  input wire logic WR_VALID_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  logic [15:0] word_q;
  logic [7:0] lo_q;
  // array word one cycle back, and its low byte once the word is taken
  always_ff @(posedge REF_CLK_IN) begin
    word_q <= RD_WORD_IN;
    if (RD_WORD_TAKEN_OUT) begin
      lo_q <= word_q[7:0];
    end
  end
  // write phases held for two cycles
  sequence lat_wr;
    (WR_PHASE_IN && !WR_ZERO_LAT_IN) [*2];
  endsequence
  sequence zl_wr;
    (WR_PHASE_IN && WR_ZERO_LAT_IN) [*2];
  endsequence
  chk_valid_pulse: assert property (WR_VALID_OUT |=> !WR_VALID_OUT)
    else $error("write word pulse too long");
  chk_zl_full_word: assert property (zl_wr ##0 WR_VALID_OUT |-> WR_BYTE_EN_OUT == DDRBL_EN_ALL)
    else $error("zero latency word masked");
  chk_zl_strobe_low: assert property (zl_wr |-> !READ_STROBE_WRITE_MASK_OUT && !DQ_OE_OUT)
    else $error("strobe not low in zero latency write");
  chk_mask_released: assert property (lat_wr |-> !READ_STROBE_WRITE_MASK_OE_OUT && !DQ_OE_OUT)
    else $error("device drives pins in masked write");
  chk_byte_a_first: assert property (RD_WORD_TAKEN_OUT |->
    READ_STROBE_WRITE_MASK_OUT && DQ_OE_OUT && DQ_OUT == word_q[15:8])
    else $error("upper byte not shown with strobe high");
  chk_byte_b_second: assert property ($fell(READ_STROBE_WRITE_MASK_OUT) && DQ_OE_OUT |->
    DQ_OUT == lo_q)
    else $error("lower byte not shown with strobe low");
  chk_rise_new_word: assert property ($rose(READ_STROBE_WRITE_MASK_OUT) && RD_PHASE_IN |->
    RD_WORD_TAKEN_OUT)
    else $error("strobe rise without new word");
  chk_data_strobed: assert property (DQ_OE_OUT |-> READ_STROBE_WRITE_MASK_OE_OUT)
    else $error("data driven without strobe");
endmodule
`default_nettype wire

// ### testbench/ddrbl_host_model.sv
// host model: bus master driving bus clock, select, write data and mask
`timescale 1ns/100ps
`default_nettype none
module ddrbl_host_model (
  // pins towards the device
  output logic bus_clk_out,
  output logic cs_b_out,
  output logic [7:0] dq_out,
  output logic mask_out
);
  // idle bus: clock still and low, deselected
  initial begin
    bus_clk_out = 1'b0;
    cs_b_out = 1'b1;
    dq_out = 8'h00;
    mask_out = 1'b0;
  end
  // one write word, byte a around the rise and byte b around the fall
  task automatic word(input logic [7:0] a, b, input logic ma, mb, drv);
    cs_b_out = 1'b0;
    dq_out = a;
    mask_out = drv ? ma : ~mask_out;
    #12 bus_clk_out = 1'b1;
    #12 dq_out = b;
    mask_out = drv ? mb : ~mask_out;
    #12 bus_clk_out = 1'b0;
    #12 dq_out = ~dq_out;
    mask_out = ~mask_out;
  endtask
  // one read clock cycle with the data lines inverted at its start and end
  task automatic rd_cycle();
    cs_b_out = 1'b0;
    dq_out = ~dq_out;
    #12 bus_clk_out = 1'b1;
    #24 bus_clk_out = 1'b0;
    #12 dq_out = ~dq_out;
  endtask
  // end of frame: deselect with the clock idle
  task automatic done();
    cs_b_out = 1'b1;
    dq_out = ~dq_out;
  endtask
endmodule
`default_nettype wire

// ### testbench/ddrbl_lane_bench.sv
// bench: masked writes, zero-latency write and reads through the lane block
`timescale 1ns/100ps
`default_nettype none
module ddrbl_lane_bench
  import ddrbl_pkg::*;
;
  logic clk, rst_b = 0, rd_ph = 0, wr_ph = 0, zl = 0, h_clk, h_cs, h_m, dq_oe, rs_o, rs_oe;
  logic taken, wr_v;
  logic [15:0] rd_word = 16'h0000, wword;
  logic [7:0] h_dq, dq_o;
  logic [1:0] wr_en;
  int miscompares = 0, n_compared = 0;
  ddrbl_host_model ddrbl_host_model_inst (.bus_clk_out(h_clk), .cs_b_out(h_cs),
    .dq_out(h_dq), .mask_out(h_m));
  ddrbl_lane ddrbl_lane_inst (.REF_CLK_IN(clk), .RST_B_IN(rst_b), .CE_IN(1'b1),
    .BUS_CLOCK_IN(h_clk), .CS_B_IN(h_cs), .DQ_IN(dq_oe ? dq_o : h_dq),
    .READ_STROBE_WRITE_MASK_IN(rs_oe ? rs_o : h_m), .DQ_OUT(dq_o), .DQ_OE_OUT(dq_oe),
    .READ_STROBE_WRITE_MASK_OUT(rs_o), .READ_STROBE_WRITE_MASK_OE_OUT(rs_oe),
    .RD_PHASE_IN(rd_ph), .WR_PHASE_IN(wr_ph), .WR_ZERO_LAT_IN(zl), .RD_WORD_IN(rd_word),
    .RD_WORD_TAKEN_OUT(taken), .WR_WORD_OUT(wword), .WR_BYTE_EN_OUT(wr_en),
    .WR_VALID_OUT(wr_v));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task check(input logic [15:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // send one word and judge the captured word and its enables
  task put_word(input logic [7:0] a, b, input logic ma, mb);
    int i;
    // start on a falling edge so no host pin moves on a sampling edge
    @(negedge clk);
    fork
      ddrbl_host_model_inst.word(a, b, ma, mb, !zl);
      for (i = 0; i < 40 && wr_v !== 1'b1; i++) begin @(posedge clk); #1; end
    join
    check(wword, {a, b});
    check({14'h0, wr_en}, zl ? 16'h3 : {14'h0, ~ma, ~mb});
  endtask
  task wait_rs(input logic v);
    int i;
    for (i = 0; i < 40 && rs_o !== v; i++) begin @(posedge clk); #1; end
  endtask
  // all four mask codes on back-to-back latency write words
  task t_mask;
    int m;
    @(negedge clk) wr_ph = 1'b1;
    for (m = 0; m < 4; m++) put_word(8'h5a + m[7:0], 8'ha5 - m[7:0], m[1], m[0]);
    ddrbl_host_model_inst.done();
    @(negedge clk) wr_ph = 1'b0;
    $display("mask writes done");
  endtask
  // zero-latency write with the mask line left to the device
  task t_zl;
    @(negedge clk) zl = 1'b1;
    wr_ph = 1'b1;
    repeat (2) @(negedge clk);
    put_word(8'hc3, 8'h3c, 1'b1, 1'b1);
    // bus still selected here, so the device owns the strobe line
    check({14'h0, rs_oe, rs_o}, 16'h2);
    ddrbl_host_model_inst.done();
    @(negedge clk) wr_ph = 1'b0;
    zl = 1'b0;
    $display("zero latency write done");
  endtask
  // two read words, upper byte with strobe high then lower with strobe low
  task t_read;
    logic [15:0] w[2];
    int k;
    w = '{16'h1234, 16'hfedc};
    @(negedge clk) rd_ph = 1'b1;
    for (k = 0; k < 2; k++) begin
      @(negedge clk) rd_word = w[k];
      fork
        ddrbl_host_model_inst.rd_cycle();
        begin
          wait_rs(1'b1);
          check({8'h0, dq_o}, {8'h0, w[k][15:8]});
          check({14'h0, dq_oe, rs_oe}, 16'h3);
          check({15'h0, taken}, 16'h1);
          wait_rs(1'b0);
          check({8'h0, dq_o}, {8'h0, w[k][7:0]});
        end
      join
    end
    ddrbl_host_model_inst.done();
    @(negedge clk) rd_ph = 1'b0;
    $display("reads done");
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    repeat (6) @(negedge clk);
    t_mask;
    t_zl;
    t_read;
    complete_run;
  end
  // watchdog well beyond the expected run of under a microsecond
  initial begin
    #20000;
    miscompares++;
    complete_run;
  end
endmodule
bind ddrbl_lane ddrbl_lane_assertions ddrbl_lane_assertions_inst (.REF_CLK_IN, .RST_B_IN,
  .RD_PHASE_IN, .WR_PHASE_IN, .WR_ZERO_LAT_IN, .RD_WORD_IN, .DQ_OUT, .DQ_OE_OUT,
  .READ_STROBE_WRITE_MASK_OUT, .READ_STROBE_WRITE_MASK_OE_OUT, .RD_WORD_TAKEN_OUT,
  .WR_BYTE_EN_OUT, .WR_VALID_OUT);
`default_nettype wire
